/* cis_core_interrupt_sequencer.sv */
// Interrupt flag, enable and vectoring sequencer for the small core
`timescale 1ns/1ps
`default_nettype none
module cis_core_interrupt_sequencer import cis_pkg::*; #(
	parameter int NUM_CORE = 1,
	parameter int NUM_PERIPH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control register access
	input wire logic ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	output logic global_irq_enable,
	output logic periph_group_irq_enable,
	// External pin
	input wire logic ext_pin,
	input wire logic ext_pin_edge_select,
	input wire logic ext_pin_irq_enable,
	input wire logic ext_pin_flag_clr,
	output logic ext_pin_irq_flag,
	// Pin-change flags, software-owned elsewhere
	input wire logic [5:0] pin_change_flags,
	input wire logic pin_change_irq_enable,
	output logic pin_change_summary_flag,
	// Core sources with enables on core_en, outside the control register
	input wire logic [NUM_CORE-1:0] core_evt,
	input wire logic [NUM_CORE-1:0] core_en,
	input wire logic [NUM_CORE-1:0] core_flag_clr,
	output logic [NUM_CORE-1:0] core_flag,
	// Peripheral sources
	input wire logic [NUM_PERIPH-1:0] periph_evt,
	input wire logic [NUM_PERIPH-1:0] periph_enable_reg_one,
	input wire logic [NUM_PERIPH-1:0] periph_flag_clr,
	input wire logic [NUM_PERIPH-1:0] periph_wake_capable,
	output logic [NUM_PERIPH-1:0] periph_flag_reg_one,
	// Core pipeline
	input wire logic [14:0] core_pc,
	input wire logic [7:0] core_w,
	input wire logic [7:0] core_status,
	input wire logic [4:0] core_bsr,
	input wire logic [15:0] core_fsr0,
	input wire logic [15:0] core_fsr1,
	input wire logic [6:0] core_pclath,
	input wire logic return_from_irq_instr,
	input wire logic sleep_instr,
	input wire logic [14:0] stack_top,
	// Vectoring outputs
	output logic flush,
	output logic push,
	output logic pop,
	output logic pc_load,
	output logic [14:0] pc_load_addr,
	output logic ctx_restore,
	output logic sleeping,
	output logic [1:0] phase,
	output logic [7:0] shadow_w,
	output logic [7:0] shadow_status,
	output logic [4:0] shadow_bsr,
	output logic [15:0] shadow_fsr0,
	output logic [15:0] shadow_fsr1,
	output logic [6:0] shadow_pclath
);
	if (NUM_CORE < 1 || NUM_PERIPH < 1) begin : g_bad_counts
		$error("Source counts must be at least one");
	end

	// ****************
	// Phase divider
	// ****************
	logic [1:0] phase_q;
	wire q1 = (phase_q == CIS_PHASE_Q1);
	wire q4 = (phase_q == CIS_PHASE_Q4);
	always_ff @(posedge clk) begin
		if (rst || sleeping) phase_q <= CIS_PHASE_Q1;
		else phase_q <= phase_q + 2'h1;
	end
	assign phase = phase_q;

	// ****************
	// Pin synchroniser and edge
	// ****************
	logic pin_s1_q, pin_s2_q, pin_s3_q;
	always_ff @(posedge clk) begin
		pin_s1_q <= ext_pin;
		pin_s2_q <= pin_s1_q;
		pin_s3_q <= pin_s2_q;
	end
	wire pin_edge = ext_pin_edge_select ? (pin_s2_q & ~pin_s3_q)
		: (~pin_s2_q & pin_s3_q);

	// ****************
	// Flags
	// ****************
	logic ctl_glb_q, ctl_grp_q, pin_flag_q;
	logic [NUM_CORE-1:0] core_flag_q;
	logic [NUM_PERIPH-1:0] per_flag_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_flag_q <= 1'b0;
			core_flag_q <= '0;
			per_flag_q <= '0;
		end else begin
			// Set wins over clear; enables never gate a flag
			pin_flag_q <= (pin_flag_q & ~ext_pin_flag_clr) | pin_edge;
			core_flag_q <= (core_flag_q & ~core_flag_clr) | core_evt;
			per_flag_q <= (per_flag_q & ~periph_flag_clr) | periph_evt;
		end
	end
	assign ext_pin_irq_flag = pin_flag_q;
	assign core_flag = core_flag_q;
	assign periph_flag_reg_one = per_flag_q;
	assign pin_change_summary_flag = |pin_change_flags;

	// ****************
	// Request decision
	// ****************
	wire src_core = (pin_flag_q & ext_pin_irq_enable)
		| (pin_change_summary_flag & pin_change_irq_enable)
		| (|(core_flag_q & core_en));
	wire src_per = ctl_grp_q & (|(per_flag_q & periph_enable_reg_one));
	wire req_raw = src_core | src_per;
	logic req_q;
	always_ff @(posedge clk) begin
		if (rst) req_q <= 1'b0;
		else if (q1) req_q <= req_raw;
	end
	// Wake only from sources running without the system clock
	wire wake_req = (pin_flag_q & ext_pin_irq_enable)
		| (pin_change_summary_flag & pin_change_irq_enable)
		| (ctl_grp_q & (|(per_flag_q & periph_enable_reg_one
		& periph_wake_capable)));

	// ****************
	// Sequencer
	// ****************
	cis_state_t st_q, st_d;
	wire take = req_q & ctl_glb_q & q4;
	always_comb begin
		st_d = st_q;
		case (st_q)
			CIS_RUN: begin
				if (take) st_d = CIS_FLUSH;
				else if (sleep_instr) st_d = CIS_SLEEP;
			end
			CIS_FLUSH: if (q4) st_d = CIS_RUN;
			CIS_SLEEP: if (wake_req) st_d = CIS_WAKE;
			// Following instruction runs before any vector
			CIS_WAKE: if (q4) st_d = CIS_RUN;
			default: st_d = CIS_RUN;
		endcase
	end
	wire enter = (st_q == CIS_RUN) & take;
	wire ret = return_from_irq_instr & (st_q == CIS_RUN);
	always_ff @(posedge clk) begin
		if (rst) st_q <= CIS_RUN;
		else st_q <= st_d;
	end

	// ****************
	// Control register
	// ****************
	always_ff @(posedge clk) begin
		if (rst) begin
			ctl_glb_q <= CIS_CTRL_RESET[CIS_CTRL_GLOBAL_BIT];
			ctl_grp_q <= CIS_CTRL_RESET[CIS_CTRL_GROUP_BIT];
		end else begin
			if (enter) ctl_glb_q <= 1'b0;
			else if (ret) ctl_glb_q <= 1'b1;
			else if (ctrl_wr) ctl_glb_q <= ctrl_wdata[CIS_CTRL_GLOBAL_BIT];
			if (ctrl_wr) ctl_grp_q <= ctrl_wdata[CIS_CTRL_GROUP_BIT];
		end
	end
	assign global_irq_enable = ctl_glb_q;
	assign periph_group_irq_enable = ctl_grp_q;

	// ****************
	// Shadow context and core strobes
	// ****************
	always_ff @(posedge clk) begin
		if (rst) begin
			shadow_w <= 8'h00;
			shadow_status <= 8'h00;
			shadow_bsr <= 5'h00;
			shadow_fsr0 <= 16'h0000;
			shadow_fsr1 <= 16'h0000;
			shadow_pclath <= 7'h00;
		end else if (enter) begin
			shadow_w <= core_w;
			shadow_status <= core_status & CIS_STATUS_SAVE_MASK;
			shadow_bsr <= core_bsr;
			shadow_fsr0 <= core_fsr0;
			shadow_fsr1 <= core_fsr1;
			shadow_pclath <= core_pclath;
		end
	end
	logic pc_load_q, push_q, pop_q, rest_q;
	logic [14:0] addr_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			pc_load_q <= 1'b0;
			push_q <= 1'b0;
			pop_q <= 1'b0;
			rest_q <= 1'b0;
			addr_q <= CIS_PC_RESET;
		end else begin
			pc_load_q <= enter | ret;
			push_q <= enter;
			pop_q <= ret;
			rest_q <= ret;
			if (enter) addr_q <= CIS_VECTOR_ADDR;
			else if (ret) addr_q <= stack_top;
		end
	end
	assign flush = (st_q == CIS_FLUSH);
	assign push = push_q;
	assign pop = pop_q;
	assign ctx_restore = rest_q;
	assign pc_load = pc_load_q;
	assign pc_load_addr = addr_q;
	assign sleeping = (st_q == CIS_SLEEP);

	// ****************
	// Checks
	// ****************
	AST_RESET_CLEARS: assert property (@(posedge clk) rst |=> !global_irq_enable
		&& !periph_group_irq_enable) else $error("Enables not cleared by reset");
	AST_NO_TAKE_WHEN_OFF: assert property (@(posedge clk) disable iff (rst)
		!ctl_glb_q |-> !enter) else $error("Vectored with global enable clear");
	AST_ENTRY_SEQ: assert property (@(posedge clk) disable iff (rst) enter |=>
		!global_irq_enable && push && pc_load && pc_load_addr == CIS_VECTOR_ADDR && flush)
		else $error("Entry sequence wrong");
	AST_RETURN_SETS: assert property (@(posedge clk) disable iff (rst) ret |=>
		global_irq_enable && pop && ctx_restore) else $error("Return sequence wrong");
	AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (rst)
		periph_evt[0] |=> periph_flag_reg_one[0]) else $error("Flag not set");
	AST_PIN_EDGE: assert property (@(posedge clk) disable iff (rst) pin_edge |=>
		ext_pin_irq_flag) else $error("Pin edge lost");
	AST_SAMPLE_Q1: assert property (@(posedge clk) disable iff (rst)
		!$past(q1) && !$past(rst) |-> $stable(req_q)) else $error("Request sampled off Q1");
	AST_LATENCY: assert property (@(posedge clk) disable iff (rst)
		(st_q == CIS_RUN && req_raw && ctl_glb_q && !return_from_irq_instr && !sleep_instr
		&& !ctrl_wr && !flush) |-> ##[1:8] (enter || !req_raw || !ctl_glb_q))
		else $error("Request not taken in time");
	AST_SHADOW_MASK: assert property (@(posedge clk) disable iff (rst) enter |=>
		(shadow_status & ~CIS_STATUS_SAVE_MASK) == 8'h00) else $error("Status mask wrong");
	AST_WAKE_CONT: assert property (@(posedge clk) disable iff (rst)
		st_q == CIS_SLEEP && st_d == CIS_WAKE |=> (st_q == CIS_WAKE && !pc_load)[*4])
		else $error("Vectored before following instruction");
	COV_ENTRY: cover property (@(posedge clk) enter);
	COV_RETURN: cover property (@(posedge clk) ret);
	COV_WAKE: cover property (@(posedge clk) st_q == CIS_SLEEP ##1 st_q == CIS_WAKE);
endmodule
`default_nettype wire

/* cis_core_model.sv */
// Core pipeline model: program counter and one-deep return stack
`timescale 1ns/1ps
`default_nettype none
module cis_core_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Sequencer strobes
	input wire logic push,
	input wire logic pc_load,
	input wire logic [14:0] pc_load_addr,
	// Context toward the sequencer
	output logic [14:0] core_pc,
	output logic [14:0] stack_top
);
	always_ff @(posedge clk) begin
		if (rst) begin
			core_pc <= 15'h0100;
			stack_top <= 15'h7fff;
		end else begin
			if (push) stack_top <= core_pc;
			core_pc <= pc_load ? pc_load_addr : core_pc + 15'h0001;
		end
	end
endmodule
`default_nettype wire

/* cis_pkg.sv */
// Constants and types of the core interrupt sequencer
package cis_pkg;

	localparam logic [14:0] CIS_VECTOR_ADDR = 15'h0004;
	localparam logic [14:0] CIS_PC_RESET = 15'h0000;
	localparam int CIS_CTRL_GLOBAL_BIT = 7;
	localparam int CIS_CTRL_GROUP_BIT = 6;
	localparam logic [7:0] CIS_CTRL_RESET = 8'h00;
	localparam int CIS_PHASES_PER_CYCLE = 4;
	localparam logic [1:0] CIS_PHASE_Q1 = 2'h0;
	localparam logic [1:0] CIS_PHASE_Q4 = 2'h3;
	// Status bits kept out of the shadow copy (timeout, power-down)
	localparam logic [7:0] CIS_STATUS_SAVE_MASK = 8'he7;

	typedef enum logic [1:0] {CIS_RUN, CIS_FLUSH, CIS_SLEEP, CIS_WAKE} cis_state_t;
endpackage

/* core_interrupt_sequencer_bench.sv */
// Self-checking bench of the interrupt sequencer
`timescale 1ns/1ps
`default_nettype none
module core_interrupt_sequencer_bench;
	import cis_pkg::*;
	logic clk = 0, rst = 1, ctrl_wr = 0, ext_pin = 0, ext_pin_edge_select = 1;
	logic ext_pin_irq_enable = 0, ext_pin_flag_clr = 0, pin_change_irq_enable = 0;
	logic return_from_irq_instr = 0, sleep_instr = 0;
	logic [7:0] ctrl_wdata = 8'h00, core_w = 8'h5a, core_status = 8'hff;
	logic [5:0] pin_change_flags = 6'h00;
	logic [0:0] core_evt = 1'h0, core_en = 1'h1, core_flag_clr = 1'h0, core_flag;
	logic [7:0] periph_evt = 8'h00, periph_enable_reg_one = 8'h01, periph_flag_clr = 8'h00;
	logic [7:0] periph_wake_capable = 8'h00, periph_flag_reg_one, shadow_w, shadow_status;
	logic [14:0] core_pc, stack_top, pc_load_addr;
	logic [4:0] core_bsr = 5'h13, shadow_bsr;
	logic [15:0] core_fsr0 = 16'h1234, core_fsr1 = 16'h5678, shadow_fsr0, shadow_fsr1;
	logic [6:0] core_pclath = 7'h2a, shadow_pclath;
	logic global_irq_enable, periph_group_irq_enable, ext_pin_irq_flag, pin_change_summary_flag;
	logic flush, push, pop, pc_load, ctx_restore, sleeping;
	logic [1:0] phase;
	int failures = 0, tests_run = 0, cyc = 0;

	cis_core_interrupt_sequencer dut (.clk, .rst, .ctrl_wr, .ctrl_wdata, .global_irq_enable,
		.periph_group_irq_enable, .ext_pin, .ext_pin_edge_select, .ext_pin_irq_enable,
		.ext_pin_flag_clr, .ext_pin_irq_flag, .pin_change_flags, .pin_change_irq_enable,
		.pin_change_summary_flag, .core_evt, .core_en, .core_flag_clr, .core_flag, .periph_evt,
		.periph_enable_reg_one, .periph_flag_clr, .periph_wake_capable, .periph_flag_reg_one,
		.core_pc, .core_w, .core_status, .core_bsr, .core_fsr0, .core_fsr1, .core_pclath,
		.return_from_irq_instr, .sleep_instr, .stack_top, .flush, .push, .pop, .pc_load,
		.pc_load_addr, .ctx_restore, .sleeping, .phase, .shadow_w, .shadow_status, .shadow_bsr,
		.shadow_fsr0, .shadow_fsr1, .shadow_pclath);
	cis_core_model core (.clk, .rst, .push, .pc_load, .pc_load_addr, .core_pc, .stack_top);

	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			failures++;
			end_sim();
		end
	end

	// ********************
	// Helpers
	// ********************
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr_ctrl(input logic [7:0] v);
		@(posedge clk);
		ctrl_wr <= 1'b1;
		ctrl_wdata <= v;
		@(posedge clk);
		ctrl_wr <= 1'b0;
		#1;
	endtask
	task automatic wait_load(output int n);
		n = 0;
		while (pc_load !== 1'b1 && n < 40) begin
			tick(1);
			n++;
		end
	endtask
	task automatic quiet(input int n, input string nm);
		int k;
		k = 0;
		repeat (n) begin
			tick(1);
			if (pc_load === 1'b1) k++;
		end
		chk(nm, 16'h0, k[15:0]);
	endtask

	// ********************
	// Scenarios
	// ********************
	task automatic t_reset;
		chk("global", 16'h0, global_irq_enable);
		chk("group", 16'h0, periph_group_irq_enable);
		@(posedge clk) pin_change_flags <= 6'h24;
		tick(1);
		chk("summary set", 16'h1, pin_change_summary_flag);
		@(posedge clk) pin_change_flags <= 6'h00;
		tick(1);
		chk("summary clear", 16'h0, pin_change_summary_flag);
	endtask
	task automatic t_pending;
		int n;
		wr_ctrl(8'h80);
		chk("global set", 16'h1, global_irq_enable);
		@(posedge clk) periph_evt <= 8'h01;
		@(posedge clk) periph_evt <= 8'h00;
		tick(2);
		chk("periph flag", 16'h1, periph_flag_reg_one[0]);
		quiet(24, "no group");
		wr_ctrl(8'hc0);
		wait_load(n);
		chk("vector", 16'h0004, pc_load_addr);
		chk("push", 16'h1, push);
		chk("global cleared", 16'h0, global_irq_enable);
		chk("flush", 16'h1, flush);
		chk("shadow w", 16'h5a, shadow_w);
		chk("shadow status", 16'he7, shadow_status);
		chk("shadow fsr1", 16'h5678, shadow_fsr1);
		chk("source flag", 16'h0001, periph_flag_reg_one);
		@(posedge clk) core_evt <= 1'h1;
		@(posedge clk) core_evt <= 1'h0;
		tick(2);
		chk("core flag", 16'h1, core_flag);
		quiet(24, "handler");
	endtask
	task automatic t_return;
		int n;
		logic [14:0] sa;
		@(posedge clk) begin
			periph_flag_clr <= 8'hff;
			core_flag_clr <= 1'h1;
		end
		@(posedge clk) begin
			periph_flag_clr <= 8'h00;
			core_flag_clr <= 1'h0;
		end
		// Return after one instruction cycle plus one clock, after a Q1 sample of the cleared flags
		tick(CIS_PHASES_PER_CYCLE + 1);
		sa = stack_top;
		@(posedge clk) return_from_irq_instr <= 1'b1;
		@(posedge clk) return_from_irq_instr <= 1'b0;
		#1;
		wait_load(n);
		chk("return addr", {1'b0, sa}, pc_load_addr);
		chk("pop", 16'h1, pop);
		chk("restore", 16'h1, ctx_restore);
		tick(1);
		chk("global back", 16'h1, global_irq_enable);
		quiet(12, "flags cleared");
	endtask
	task automatic t_latency;
		int n;
		@(posedge clk) core_evt <= 1'h1;
		@(posedge clk) core_evt <= 1'h0;
		#1;
		wait_load(n);
		chk("latency", 16'h1, 16'(n <= 15));
		chk("vector", 16'h0004, pc_load_addr);
	endtask
	task automatic t_pin;
		@(posedge clk) ext_pin <= 1'b1;
		tick(6);
		chk("rising", 16'h1, ext_pin_irq_flag);
		@(posedge clk) ext_pin_flag_clr <= 1'b1;
		@(posedge clk) ext_pin_flag_clr <= 1'b0;
		@(posedge clk) ext_pin <= 1'b0;
		tick(6);
		chk("falling ignored", 16'h0, ext_pin_irq_flag);
		@(posedge clk) ext_pin_edge_select <= 1'b0;
		@(posedge clk) ext_pin <= 1'b1;
		tick(6);
		chk("rising ignored", 16'h0, ext_pin_irq_flag);
		@(posedge clk) ext_pin <= 1'b0;
		tick(6);
		chk("falling", 16'h1, ext_pin_irq_flag);
		@(posedge clk) begin
			ext_pin_flag_clr <= 1'b1;
			ext_pin_edge_select <= 1'b1;
		end
		@(posedge clk) ext_pin_flag_clr <= 1'b0;
	endtask
	task automatic t_sleep;
		int n;
		wr_ctrl(8'h40);
		@(posedge clk) ext_pin_irq_enable <= 1'b1;
		@(posedge clk) sleep_instr <= 1'b1;
		@(posedge clk) sleep_instr <= 1'b0;
		#1;
		chk("asleep", 16'h1, sleeping);
		@(posedge clk) periph_evt <= 8'h01;
		@(posedge clk) periph_evt <= 8'h00;
		tick(4);
		chk("no clocked wake", 16'h1, sleeping);
		@(posedge clk) periph_flag_clr <= 8'hff;
		@(posedge clk) periph_flag_clr <= 8'h00;
		@(posedge clk) ext_pin <= 1'b1;
		quiet(12, "wake no vector");
		chk("awake", 16'h0, sleeping);
		@(posedge clk) ext_pin <= 1'b0;
		tick(4);
		@(posedge clk) ext_pin_flag_clr <= 1'b1;
		@(posedge clk) ext_pin_flag_clr <= 1'b0;
		tick(CIS_PHASES_PER_CYCLE + 1);
		wr_ctrl(8'hc0);
		@(posedge clk) sleep_instr <= 1'b1;
		@(posedge clk) sleep_instr <= 1'b0;
		@(posedge clk) ext_pin <= 1'b1;
		#1;
		wait_load(n);
		chk("wake vector", 16'h0004, pc_load_addr);
		chk("after sleep", 16'h1, 16'(n >= 2 * CIS_PHASES_PER_CYCLE));
	endtask
	task automatic t_rst_mid;
		chk("group held", 16'h1, periph_group_irq_enable);
		@(posedge clk) rst <= 1'b1;
		tick(2);
		@(posedge clk) rst <= 1'b0;
		tick(1);
		chk("reset group", 16'h0, periph_group_irq_enable);
		chk("reset global", 16'h0, global_irq_enable);
		chk("reset pin flag", 16'h0, ext_pin_irq_flag);
		quiet(12, "reset no vector");
	endtask

	task automatic end_sim;
		$display("checks %0d errors %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		tick(1);
		t_reset();
		t_pending();
		t_return();
		t_latency();
		t_return();
		t_pin();
		t_sleep();
		t_rst_mid();
		end_sim();
	end
endmodule
`default_nettype wire
